// ---- rtl/sps_pkg.sv ----
/*
  Constants and types for the stepper phase sequencer.
  Assumes a single 100 MHz core clock.
*/
package sps_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  // hold time per farad of timing capacitance, in ms
  localparam longint      HOLD_MS_PER_F   = 64'hB2D05E00;
  // default timing capacitance in picofarads (0.1 uF)
  localparam longint      TIMING_CAP_PF   = 64'h186A0;
  // hold in us = HOLD_MS_PER_F * cap_pf * 1e-9
  localparam longint      HOLD_TIME_US    = (HOLD_MS_PER_F * TIMING_CAP_PF) / 64'h3B9ACA00;
  localparam longint      HOLD_CYCLES_L   = (HOLD_TIME_US * 64'hF4240) / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYCLES     = (HOLD_CYCLES_L < 1) ? 1 : int'(HOLD_CYCLES_L);
  localparam int unsigned HOLD_W          = 32;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  localparam logic [2:0]  IDX_START       = 3'h0;
  localparam logic [2:0]  IDX_HALF_STEP   = 3'h1;
  localparam logic [2:0]  IDX_FULL_STEP   = 3'h2;

  typedef struct packed {
    logic phase1_polarity;
    logic phase2_polarity;
    logic phase1_disable;
    logic phase2_disable;
  } sps_phase_s;

  localparam sps_phase_s PHASE_START = 4'h0;

  typedef struct packed {
    logic step;
    logic direction;
    logic half_full_select;
  } sps_in_s;

  // idle level of the inputs, so no false edge follows reset
  localparam sps_in_s IN_IDLE = 3'h7;

  typedef enum logic {SPS_IDLE, SPS_HOLD} sps_hold_e;

endpackage

// ---- rtl/sps_sequencer.sv ----
/*
  Step/direction translator with retriggerable current-reduce timer.
  Assumes step, direction and mode asynchronous, and reset_n synchronous, to core_clk.
*/
`timescale 1ns/1ps
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES
)(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       reset_n,
  input  wire logic       step,
  input  wire logic       direction,
  input  wire logic       half_full_select,
  output logic            phase1_polarity,
  output logic            phase2_polarity,
  output logic            phase1_disable,
  output logic            phase2_disable,
  output logic            origin_flag,
  output logic            current_reduce_out
);

  // ---------------------------------------------------------------
  // input synchronisers and edge detect
  // ---------------------------------------------------------------
  sps_in_s    sync1_q;
  sps_in_s    sync2_q;
  logic       step_prev_q;
  logic       step_fall;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q     <= IN_IDLE;
      sync2_q     <= IN_IDLE;
      step_prev_q <= IN_IDLE.step;
    end
    else
    begin
      sync1_q     <= {step, direction, half_full_select};
      sync2_q     <= sync1_q;
      step_prev_q <= sync2_q.step;
    end
  end

  assign step_fall = step_prev_q & ~sync2_q.step & reset_n;

  // ---------------------------------------------------------------
  // phase decode
  // ---------------------------------------------------------------
  // even index: both windings on; odd: one disabled (half step)
  function automatic sps_phase_s decode(input logic [2:0] idx);
    sps_phase_s p;
    p.phase1_polarity = idx[2] ^ idx[1];
    p.phase2_polarity = idx[2];
    p.phase1_disable  = idx[0] & ~idx[1];
    p.phase2_disable  = idx[0] & idx[1];
    return p;
  endfunction

  // ---------------------------------------------------------------
  // sequencer index
  // ---------------------------------------------------------------
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  sps_phase_s phase_q;
  sps_phase_s phase_d;
  logic       origin_q;
  logic       origin_d;

  always_comb
  begin
    idx_d = idx_q;
    if (!reset_n)
      idx_d = IDX_START;
    else if (step_fall)
    begin
      if (sync2_q.half_full_select)
        idx_d = sync2_q.direction ? idx_q + IDX_FULL_STEP : idx_q - IDX_FULL_STEP;
      else
        idx_d = sync2_q.direction ? idx_q + IDX_HALF_STEP : idx_q - IDX_HALF_STEP;
    end
    phase_d  = decode(idx_d);
    origin_d = (idx_d != IDX_START);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idx_q    <= IDX_START;
      phase_q  <= PHASE_START;
      origin_q <= 1'h0;
    end
    else
    begin
      idx_q    <= idx_d;
      phase_q  <= phase_d;
      origin_q <= origin_d;
    end
  end

  // ---------------------------------------------------------------
  // current-reduce hold timer
  // ---------------------------------------------------------------
  sps_hold_e         hold_q;
  sps_hold_e         hold_d;
  logic [HOLD_W-1:0] cnt_q;
  logic [HOLD_W-1:0] cnt_d;
  logic              cro_q;
  logic              cro_d;

  always_comb
  begin
    hold_d = hold_q;
    cnt_d  = cnt_q;
    if (step_fall)
    begin
      hold_d = SPS_HOLD;
      cnt_d  = HOLD_W'(HOLD_COUNT);
    end
    else
    begin
      unique case (hold_q)
        SPS_IDLE: cnt_d = '0;
        SPS_HOLD:
        begin
          cnt_d = cnt_q - HOLD_W'(1);
          if (cnt_q == HOLD_W'(1))
            hold_d = SPS_IDLE;
        end
      endcase
    end
    // output flop mirrors the hold state
    cro_d = (hold_d == SPS_HOLD);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_q <= SPS_IDLE;
      cnt_q  <= '0;
      cro_q  <= 1'h0;
    end
    else
    begin
      hold_q <= hold_d;
      cnt_q  <= cnt_d;
      cro_q  <= cro_d;
    end
  end

  assign phase1_polarity    = phase_q.phase1_polarity;
  assign phase2_polarity    = phase_q.phase2_polarity;
  assign phase1_disable     = phase_q.phase1_disable;
  assign phase2_disable     = phase_q.phase2_disable;
  assign origin_flag        = origin_q;
  assign current_reduce_out = cro_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_fall;
    step_fall;
  endsequence

  property p_cro_rise;
    @(posedge core_clk) disable iff (rst) s_fall |=> current_reduce_out;
  endproperty
  a_cro_rise: assert property (p_cro_rise) else $error("no current reduce after step");

  property p_cro_fall;
    @(posedge core_clk) disable iff (rst)
      (hold_q == SPS_HOLD && cnt_q == HOLD_W'(1) && !step_fall) |=> !current_reduce_out;
  endproperty
  a_cro_fall: assert property (p_cro_fall) else $error("current reduce stuck high");

  property p_retrig;
    @(posedge core_clk) disable iff (rst)
      (current_reduce_out && step_fall) |=> (current_reduce_out && cnt_q == HOLD_W'(HOLD_COUNT));
  endproperty
  a_retrig: assert property (p_retrig) else $error("retrigger failed");

  property p_load;
    @(posedge core_clk) disable iff (rst) s_fall |=> cnt_q == HOLD_W'(HOLD_COUNT);
  endproperty
  a_load: assert property (p_load) else $error("hold count wrong");

  property p_full_fwd;
    @(posedge core_clk) disable iff (rst)
      (step_fall && sync2_q.half_full_select && sync2_q.direction) |=>
        idx_q == $past(idx_q) + IDX_FULL_STEP;
  endproperty
  a_full_fwd: assert property (p_full_fwd) else $error("full forward step wrong");

  property p_full_rev;
    @(posedge core_clk) disable iff (rst)
      (step_fall && sync2_q.half_full_select && !sync2_q.direction) |=>
        idx_q == $past(idx_q) - IDX_FULL_STEP;
  endproperty
  a_full_rev: assert property (p_full_rev) else $error("full reverse step wrong");

  property p_half;
    @(posedge core_clk) disable iff (rst)
      (step_fall && !sync2_q.half_full_select) |=>
        idx_q == ($past(sync2_q.direction) ? $past(idx_q) + IDX_HALF_STEP
                                           : $past(idx_q) - IDX_HALF_STEP);
  endproperty
  a_half: assert property (p_half) else $error("half step wrong");

  property p_reset_hold;
    @(posedge core_clk) disable iff (rst)
      !reset_n |=> (idx_q == IDX_START && !origin_flag && phase_q == PHASE_START);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset pin not honoured");

  property p_origin;
    @(posedge core_clk) disable iff (rst) origin_flag == (idx_q != IDX_START);
  endproperty
  a_origin: assert property (p_origin) else $error("origin flag mismatch");

  property p_idle_steady;
    @(posedge core_clk) disable iff (rst) !step_fall |=> idx_q == $past(idx_q) || !$past(reset_n);
  endproperty
  a_idle_steady: assert property (p_idle_steady) else $error("index moved without step");

endmodule

// ---- bench/sps_step_source.sv ----
/*
  Step pulse source standing in for the pulse generator.
  Assumes the caller enters pulse right after a core_clk rise.
*/
`timescale 1ns/1ps
module sps_step_source (
  input  wire logic core_clk,
  output logic      step,
  output logic      direction,
  output logic      half_full_select
);
  initial
  begin
    step = 1'b1;
    direction = 1'b1;
    half_full_select = 1'b1;
  end
  // mode and direction settle well before the fall
  task automatic pulse(input logic d, input logic f);
    direction <= d;
    half_full_select <= f;
    repeat (4) @(posedge core_clk);
    step <= 1'b0;
    repeat (4) @(posedge core_clk);
    step <= 1'b1;
  endtask
endmodule

// ---- bench/testbench.sv ----
/*
  Self-checking bench for the phase sequencer.
  Assumes the step source model and a short hold count.
*/
`timescale 1ns/1ps
module testbench;
  import sps_pkg::*;
  localparam int unsigned HC = 20;
  logic core_clk, rst, reset_n, step, direction, half_full_select;
  // polarity 1, polarity 2, disable 1, disable 2 per index; index 0 in the low nibble
  localparam logic [31:0] PAT = 32'h54EC9820;
  localparam int unsigned TIMEOUT = 5000;
  logic pol1, pol2, d1, d2, org, cro;
  int failures, num_checks, idx, hc, cyc;
  logic [31:0] rs;
  // pin falls, aged one cycle per stage until the design takes them
  logic [2:0] fall_sr;
  logic step_last;

  sps_step_source i_sps_step_source (.core_clk(core_clk), .step(step),
    .direction(direction), .half_full_select(half_full_select));
  sps_sequencer #(.HOLD_COUNT(HC)) i_sps_sequencer (.core_clk(core_clk),
    .rst(rst), .reset_n(reset_n), .step(step), .direction(direction),
    .half_full_select(half_full_select), .phase1_polarity(pol1),
    .phase2_polarity(pol2), .phase1_disable(d1), .phase2_disable(d2),
    .origin_flag(org), .current_reduce_out(cro));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic final_report;
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // phase pattern from the table, origin low only at index 0
  task automatic check_phase;
    logic [4:0] exp_v;
    logic [4:0] got_v;
    exp_v = {PAT[{idx[2:0], 2'h0} +: 4], idx[2:0] != 3'h0};
    got_v = {pol1, pol2, d1, d2, org};
    num_checks++;
    if (got_v !== exp_v)
    begin
      failures++;
      $display("wrong value phase exp %h got %h", exp_v, got_v);
    end
  endtask

  task automatic check_hold(input logic e);
    num_checks++;
    if (cro !== e)
    begin
      failures++;
      $display("wrong value hold exp %h got %h", e, cro);
    end
  endtask

  task automatic do_step(input logic d, input logic f);
    i_sps_step_source.pulse(d, f);
    if (reset_n)
      idx = (idx + (d ? 1 : -1) * (f ? 2 : 1)) & 7;
    @(negedge core_clk);
    check_phase();
    @(posedge core_clk);
  endtask

  // hold model: a pin fall is taken three cycles on, unless reset_n is low then
  always @(negedge core_clk)
  begin
    if (rst)
    begin
      hc = 0;
      fall_sr = 3'h0;
    end
    else if (fall_sr[2])
      hc = HC;
    check_hold(hc > 0);
    if (hc > 0)
      hc--;
    fall_sr = {fall_sr[1] & reset_n, fall_sr[0], step_last & ~step};
    step_last = step;
    cyc++;
    if (cyc > TIMEOUT)
    begin
      failures++;
      final_report();
    end
  end

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    rst = 1'b1;
    reset_n = 1'b1;
    rs = 32'h2E94;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (int m = 0; m < 4; m++)
      repeat (9) do_step(m[0], m[1]);
    repeat (HC + 2) @(posedge core_clk);
    repeat (30)
    begin
      rs = xs(rs);
      do_step(rs[0], rs[1]);
    end
    repeat (HC + 2) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    idx = 0;
    do_step(1'b1, 1'b1);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    do_step(1'b1, 1'b0);
    rst <= 1'b1;
    idx = 0;
    @(negedge core_clk);
    check_phase();
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    do_step(1'b0, 1'b1);
    repeat (HC + 2) @(posedge core_clk);
    final_report();
  end
endmodule
